// ==== shared/vic_pkg.sv ====
// constants, encodings and helpers of the vectored interrupt controller
package vic_pkg;

	// ==========================================
	// source numbering
	localparam int          NUM_SRC       = 13;
	localparam int          NUM_EXT       = 4;
	localparam int          EXT_FIRST     = 1;
	localparam int          PINS_PER_EXT  = 4;
	localparam logic [12:0] PERIPH_MASK   = 13'h1f21;
	localparam logic [12:0] HALT_WAKE_MSK = 13'h1a1f;
	localparam logic [12:0] EXT_MASK      = 13'h001e;

	// ==========================================
	// vectors
	localparam logic [15:0] VEC_RESET     = 16'hfffe;
	localparam logic [15:0] VEC_TRAP      = 16'hfffc;
	localparam logic [15:0] VEC_SRC0      = 16'hfffa;

	// ==========================================
	// sensitivity codes
	localparam logic [1:0]  SENS_FALL_LOW = 2'h0;
	localparam logic [1:0]  SENS_RISE     = 2'h1;
	localparam logic [1:0]  SENS_FALL     = 2'h2;
	localparam logic [1:0]  SENS_BOTH     = 2'h3;

	// ==========================================
	// register map and reset values
	localparam logic [7:0]  OFF_SENS      = 8'h00;
	localparam logic [7:0]  OFF_MASK      = 8'h04;
	localparam logic [7:0]  OFF_PEND      = 8'h08;
	localparam logic [7:0]  OFF_LASTVEC   = 8'h0c;
	localparam int          MASK_BIT      = 0;
	localparam logic [7:0]  SENS_RST      = 8'h00;
	localparam logic        GMASK_RST     = 1'b1;

	// ==========================================
	// sequencer states
	typedef enum logic [3:0] {
		ST_RESETVEC = 4'b0001,
		ST_IDLE     = 4'b0010,
		ST_PUSH     = 4'b0100,
		ST_LOAD     = 4'b1000
	} vic_state_t;

	// vector of numbered source n, two bytes per slot downward
	function automatic logic [15:0] vector_of(input logic [3:0] n);
		vector_of = VEC_SRC0 - {11'h000, n, 1'b0};
	endfunction

	// lowest numbered active bit wins
	function automatic logic [3:0] first_set(input logic [12:0] v);
		first_set = 4'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_set = 4'(i);
			end
		end
	endfunction

endpackage

// ==== shared/vic_ext_if.sv ====
// signals between the controller core and the external line detectors
`timescale 1ns/1ps
interface vic_ext_if;
	logic [7:0]  sens;
	logic [15:0] pins;
	logic [15:0] pin_en;
	logic [3:0]  clear;
	logic [3:0]  req;

	modport ctl   (output sens, output pins, output pin_en, output clear, input req);
	modport lines (input sens, input pins, input pin_en, input clear, output req);
endinterface

// ==== design/vic_ext_lines.sv ====
// edge and level detection of the four external interrupt lines
`timescale 1ns/1ps
module vic_ext_lines (
	// clock and reset
	input  wire logic   hclk,
	input  wire logic   hresetn,
	// detector side
	vic_ext_if.lines    ext
);

	// ==========================================
	// combined group level
	logic [3:0] level;
	logic [3:0] level_prev_reg;
	logic [7:0] sens_prev_reg;
	logic [3:0] latch_reg;
	logic [3:0] latch_next;

	always_comb begin
		for (int i = 0; i < vic_pkg::NUM_EXT; i++) begin
			// any enabled low pin pulls the group low
			level[i] = &(ext.pins[i*4 +: 4] | ~ext.pin_en[i*4 +: 4]);
		end
	end

	// ==========================================
	// request latches
	always_comb begin
		logic rise;
		logic fall;
		logic edge_hit;
		rise       = 1'b0;
		fall       = 1'b0;
		edge_hit   = 1'b0;
		latch_next = latch_reg;
		for (int i = 0; i < vic_pkg::NUM_EXT; i++) begin
			rise = level[i] & ~level_prev_reg[i];
			fall = ~level[i] & level_prev_reg[i];
			unique case (ext.sens[i*2 +: 2])
				vic_pkg::SENS_FALL_LOW: edge_hit = fall;
				vic_pkg::SENS_RISE:     edge_hit = rise;
				vic_pkg::SENS_FALL:     edge_hit = fall;
				vic_pkg::SENS_BOTH:     edge_hit = rise | fall;
			endcase
			if (ext.clear[i] || ext.sens[i*2 +: 2] != sens_prev_reg[i*2 +: 2]) begin
				latch_next[i] = 1'b0;
			end
			if (edge_hit) begin
				latch_next[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch_reg      <= 4'h0;
			level_prev_reg <= 4'hf;
			sens_prev_reg  <= vic_pkg::SENS_RST;
		end else begin
			latch_reg      <= latch_next;
			level_prev_reg <= level;
			sens_prev_reg  <= ext.sens;
		end
	end

	// ==========================================
	// request towards the core
	always_comb begin
		for (int i = 0; i < vic_pkg::NUM_EXT; i++) begin
			unique case (ext.sens[i*2 +: 2])
				vic_pkg::SENS_FALL_LOW: ext.req[i] = latch_reg[i] | ~level[i];
				vic_pkg::SENS_RISE:     ext.req[i] = latch_reg[i] & level[i];
				vic_pkg::SENS_FALL:     ext.req[i] = latch_reg[i];
				vic_pkg::SENS_BOTH:     ext.req[i] = latch_reg[i];
			endcase
		end
	end

endmodule

// ==== design/vic_top.sv ====
// vectored interrupt controller with ahb-lite register access
`timescale 1ns/1ps
module vic_top (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// external pins, four per line
	input  wire logic [15:0] ext_pins,
	input  wire logic [15:0] ext_pin_en,
	// peripheral sources
	input  wire logic [12:0] per_flag,
	input  wire logic [12:0] per_en,
	input  wire logic [12:0] per_stat_acc,
	input  wire logic [12:0] per_assoc_acc,
	// cpu core
	input  wire logic        instr_end,
	input  wire logic        trap_exec,
	input  wire logic        ret_intr,
	input  wire logic        push_done,
	output logic             push_req,
	output logic             vector_valid,
	output logic      [15:0] vector_addr,
	output logic             global_mask,
	output logic             wake_wait,
	output logic             wake_halt
);

	// ==========================================
	// state
	vic_pkg::vic_state_t state_reg;
	logic        gmask_reg;
	logic [7:0]  sens_reg;
	logic [12:0] per_pend_reg;
	logic [12:0] per_arm_reg;
	logic [12:0] per_flag_prev_reg;
	logic        trap_pend_reg;
	logic        win_trap_reg;
	logic [3:0]  win_src_reg;
	logic [15:0] last_vec_reg;
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;
	logic [12:0] req_all;
	logic [12:0] eligible;
	logic        take;
	logic        wr_sens;
	logic        wr_mask;

	vic_ext_if ext ();

	vic_ext_lines u_ext (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ext     (ext.lines)
	);

	assign ext.sens   = sens_reg;
	assign ext.pins   = ext_pins;
	assign ext.pin_en = ext_pin_en;

	always_comb begin
		for (int i = 0; i < vic_pkg::NUM_EXT; i++) begin
			ext.clear[i] = state_reg == vic_pkg::ST_LOAD && !win_trap_reg
				&& win_src_reg == 4'(i + vic_pkg::EXT_FIRST);
		end
	end

	// ==========================================
	// ahb-lite slave
	logic addr_ok;
	assign addr_ok = hsel && htrans[1] && hready;
	assign wr_sens = wr_pend_reg && wr_addr_reg == vic_pkg::OFF_SENS;
	assign wr_mask = wr_pend_reg && wr_addr_reg == vic_pkg::OFF_MASK;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata      <= 32'h0000_0000;
			hreadyout   <= 1'b0;
			hresp       <= 1'b0;
		end else begin
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			wr_pend_reg <= addr_ok && hwrite;
			wr_addr_reg <= haddr;
			if (addr_ok && !hwrite) begin
				unique case (haddr)
					vic_pkg::OFF_SENS:    hrdata <= {24'h000000, sens_reg};
					vic_pkg::OFF_MASK:    hrdata <= {31'h0000_0000, gmask_reg};
					vic_pkg::OFF_PEND:    hrdata <= {19'h00000, req_all};
					vic_pkg::OFF_LASTVEC: hrdata <= {16'h0000, last_vec_reg};
					default:              hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================
	// sensitivity register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sens_reg <= vic_pkg::SENS_RST;
		end else if (wr_sens && gmask_reg) begin
			sens_reg <= hwdata[7:0];
		end
	end

	// ==========================================
	// peripheral request latches
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			per_pend_reg      <= 13'h0000;
			per_arm_reg       <= 13'h0000;
			per_flag_prev_reg <= 13'h0000;
		end else begin
			per_flag_prev_reg <= per_flag;
			for (int i = 0; i < vic_pkg::NUM_SRC; i++) begin
				if (vic_pkg::PERIPH_MASK[i]) begin
					if (per_stat_acc[i] && per_flag[i]) begin
						per_arm_reg[i] <= 1'b1;
					end else if (per_assoc_acc[i] || !per_flag[i]) begin
						per_arm_reg[i] <= 1'b0;
					end
					if (per_flag[i] && !per_flag_prev_reg[i]) begin
						per_pend_reg[i] <= 1'b1;
					end else if (!per_flag[i] || (per_arm_reg[i] && per_assoc_acc[i])) begin
						per_pend_reg[i] <= 1'b0;
					end
				end
			end
		end
	end

	always_comb begin
		req_all = (per_pend_reg & per_en & vic_pkg::PERIPH_MASK)
			| ({9'h000, ext.req} << vic_pkg::EXT_FIRST);
		eligible = gmask_reg ? 13'h0000 : req_all;
	end

	// ==========================================
	// service sequencer
	assign take = state_reg == vic_pkg::ST_IDLE && instr_end
		&& (trap_pend_reg || eligible != 13'h0000);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg    <= vic_pkg::ST_RESETVEC;
			win_trap_reg <= 1'b0;
			win_src_reg  <= 4'h0;
			push_req     <= 1'b0;
			vector_valid <= 1'b0;
			vector_addr  <= 16'h0000;
			last_vec_reg <= 16'h0000;
		end else begin
			vector_valid <= 1'b0;
			unique case (state_reg)
				vic_pkg::ST_RESETVEC: begin
					vector_valid <= 1'b1;
					vector_addr  <= vic_pkg::VEC_RESET;
					last_vec_reg <= vic_pkg::VEC_RESET;
					state_reg    <= vic_pkg::ST_IDLE;
				end
				vic_pkg::ST_IDLE: begin
					if (take) begin
						win_trap_reg <= trap_pend_reg;
						win_src_reg  <= vic_pkg::first_set(eligible);
						push_req     <= 1'b1;
						state_reg    <= vic_pkg::ST_PUSH;
					end
				end
				vic_pkg::ST_PUSH: begin
					if (push_done) begin
						push_req  <= 1'b0;
						state_reg <= vic_pkg::ST_LOAD;
					end
				end
				vic_pkg::ST_LOAD: begin
					vector_valid <= 1'b1;
					vector_addr  <= win_trap_reg ? vic_pkg::VEC_TRAP : vic_pkg::vector_of(win_src_reg);
					last_vec_reg <= win_trap_reg ? vic_pkg::VEC_TRAP : vic_pkg::vector_of(win_src_reg);
					state_reg    <= vic_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// trap latch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trap_pend_reg <= 1'b0;
		end else if (trap_exec) begin
			trap_pend_reg <= 1'b1;
		end else if (state_reg == vic_pkg::ST_LOAD && win_trap_reg) begin
			trap_pend_reg <= 1'b0;
		end
	end

	// ==========================================
	// global mask bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gmask_reg <= vic_pkg::GMASK_RST;
		end else if (state_reg == vic_pkg::ST_LOAD) begin
			gmask_reg <= 1'b1;
		end else if (ret_intr) begin
			gmask_reg <= 1'b0;
		end else if (wr_mask) begin
			gmask_reg <= hwdata[vic_pkg::MASK_BIT];
		end
	end

	// ==========================================
	// wake outputs and mask mirror
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_wait   <= 1'b0;
			wake_halt   <= 1'b0;
			global_mask <= vic_pkg::GMASK_RST;
		end else begin
			wake_wait   <= req_all != 13'h0000;
			wake_halt   <= (req_all & vic_pkg::HALT_WAKE_MSK) != 13'h0000;
			global_mask <= gmask_reg;
		end
	end

	// ==========================================
	// checks
	chk_reset_mask_set: assert property (@(posedge hclk) disable iff (!hresetn)
		state_reg == vic_pkg::ST_RESETVEC |-> gmask_reg) else $error("mask clear in reset fetch");
	chk_masked_no_take: assert property (@(posedge hclk) disable iff (!hresetn)
		state_reg == vic_pkg::ST_IDLE && instr_end && gmask_reg && !trap_pend_reg |=> !push_req)
		else $error("masked request taken");
	chk_push_then_load: assert property (@(posedge hclk) disable iff (!hresetn)
		state_reg == vic_pkg::ST_PUSH && push_done |=> ##1 vector_valid && gmask_reg)
		else $error("vector not loaded after push");
	chk_ret_clears_mask: assert property (@(posedge hclk) disable iff (!hresetn)
		ret_intr && state_reg != vic_pkg::ST_LOAD |=> !gmask_reg) else $error("return left mask set");
	chk_trap_vector_out: assert property (@(posedge hclk) disable iff (!hresetn)
		state_reg == vic_pkg::ST_LOAD && win_trap_reg |=> vector_addr == vic_pkg::VEC_TRAP)
		else $error("trap vector wrong");
	chk_trap_wins_prio: assert property (@(posedge hclk) disable iff (!hresetn)
		take && trap_pend_reg |=> win_trap_reg) else $error("trap lost priority");
	chk_sens_write_lock: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_sens && !gmask_reg |=> $stable(sens_reg)) else $error("sensitivity written unmasked");
	chk_timebase_no_halt: assert property (@(posedge hclk) disable iff (!hresetn)
		req_all == 13'h0020 |=> wake_wait && !wake_halt) else $error("timebase two woke halt");
	chk_spi_vector_addr: assert property (@(posedge hclk) disable iff (!hresetn)
		state_reg == vic_pkg::ST_LOAD && !win_trap_reg && win_src_reg == 4'hc |=> vector_addr == 16'hffe2)
		else $error("serial vector wrong");
	chk_handler_masked: assert property (@(posedge hclk) disable iff (!hresetn)
		vector_valid && !$past(ret_intr) |-> gmask_reg) else $error("handler entered unmasked");
	chk_capture_no_halt: assert property (@(posedge hclk) disable iff (!hresetn)
		req_all == 13'h0400 |=> wake_wait && !wake_halt) else $error("capture woke halt");
	chk_ext_wakes_halt: assert property (@(posedge hclk) disable iff (!hresetn)
		(req_all & vic_pkg::EXT_MASK) != 13'h0000 |=> wake_halt) else $error("external request no halt wake");
	chk_trap_latch_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		state_reg == vic_pkg::ST_LOAD && win_trap_reg && !trap_exec |=> !trap_pend_reg)
		else $error("trap latch not cleared");

	cov_trap_service: cover property (@(posedge hclk) disable iff (!hresetn)
		state_reg == vic_pkg::ST_LOAD && win_trap_reg);
	cov_ext_service: cover property (@(posedge hclk) disable iff (!hresetn)
		state_reg == vic_pkg::ST_LOAD && !win_trap_reg && win_src_reg == 4'h1);
	cov_ret_after_vec: cover property (@(posedge hclk) disable iff (!hresetn)
		vector_valid ##[1:20] ret_intr);
	cov_slow_push: cover property (@(posedge hclk) disable iff (!hresetn)
		push_req && !push_done ##1 push_req && !push_done);
	cov_masked_waiting: cover property (@(posedge hclk) disable iff (!hresetn)
		instr_end && gmask_reg && req_all != 13'h0000);

endmodule

// ==== tb/vic_cpu_model.sv ====
// cpu core model answering the push handshake and collecting vectors
`timescale 1ns/1ps
module vic_cpu_model (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// service handshake
	input  wire logic        push_req,
	input  wire logic        vector_valid,
	input  wire logic [15:0] vector_addr,
	input  wire logic [3:0]  push_delay,
	output logic             push_done,
	// observed vectors
	output logic      [15:0] last_vec,
	output logic      [7:0]  vec_count
);
	logic [3:0] cnt;

	// ==========================================
	// context push, prompt or slow
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt       <= 4'h0;
			push_done <= 1'b0;
		end else if (!push_req) begin
			cnt       <= 4'h0;
			push_done <= 1'b0;
		end else if (cnt >= push_delay) begin
			push_done <= 1'b1;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end

	// ==========================================
	// vector fetch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_vec  <= 16'h0000;
			vec_count <= 8'h00;
		end else if (vector_valid) begin
			last_vec  <= vector_addr;
			vec_count <= vec_count + 8'h01;
		end
	end
endmodule

// ==== tb/vic_top_tb.sv ====
// self-checking bench of the vectored interrupt controller
`timescale 1ns/1ps
module vic_top_tb;
	logic        hclk          = 1'b0;
	logic        hresetn       = 1'b0;
	logic        hsel          = 1'b0;
	logic [7:0]  haddr         = 8'h00;
	logic [1:0]  htrans        = 2'h0;
	logic        hwrite        = 1'b0;
	logic [31:0] hwdata        = 32'h0;
	logic [15:0] ext_pins      = 16'hffff;
	logic [15:0] ext_pin_en    = 16'h1111;
	logic [12:0] per_flag      = 13'h0;
	logic [12:0] per_en        = 13'h1fff;
	logic [12:0] per_stat_acc  = 13'h0;
	logic [12:0] per_assoc_acc = 13'h0;
	logic [2:0]  cpu_p         = 3'h0;
	logic [3:0]  push_delay    = 4'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        push_req;
	logic        push_done;
	logic        vector_valid;
	logic        global_mask;
	logic        wake_wait;
	logic        wake_halt;
	logic [15:0] vector_addr;
	logic [15:0] last_vec;
	logic [7:0]  vec_count;
	logic [31:0] rd;
	logic        wh;
	int          bad_count     = 0;
	int          check_count   = 0;
	int          cyc           = 0;
	logic [3:0]  src [7]       = '{4'd0, 4'd5, 4'd8, 4'd9, 4'd10, 4'd11, 4'd12};
	logic [15:0] vtab [7]      = '{16'hfffa, 16'hfff0, 16'hffea, 16'hffe8, 16'hffe6, 16'hffe4, 16'hffe2};
	logic        wk [7]        = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

	always #4 hclk = ~hclk;

	vic_top uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .ext_pins(ext_pins), .ext_pin_en(ext_pin_en), .per_flag(per_flag), .per_en(per_en),
		.per_stat_acc(per_stat_acc), .per_assoc_acc(per_assoc_acc), .instr_end(cpu_p[0]),
		.trap_exec(cpu_p[1]), .ret_intr(cpu_p[2]), .push_done(push_done), .push_req(push_req),
		.vector_valid(vector_valid), .vector_addr(vector_addr), .global_mask(global_mask),
		.wake_wait(wake_wait), .wake_halt(wake_halt)
	);

	vic_cpu_model cpu (
		.hclk(hclk), .hresetn(hresetn), .push_req(push_req), .vector_valid(vector_valid),
		.vector_addr(vector_addr), .push_delay(push_delay), .push_done(push_done),
		.last_vec(last_vec), .vec_count(vec_count)
	);

	// ==========================================
	// helpers
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(nm, e, rd);
		chk("hresp", 32'h0, 32'(hresp));
	endtask

	task automatic cpu_op(input logic [2:0] p);
		@(posedge hclk);
		cpu_p <= p;
		@(posedge hclk);
		cpu_p <= 3'h0;
	endtask

	task automatic serve(input logic [15:0] v);
		logic [7:0] n;
		n = vec_count;
		cpu_op(3'h1);
		while (vec_count == n) @(posedge hclk);
		@(posedge hclk);
		chk("vector", 32'(v), 32'(last_vec));
		chk("mask set", 32'h1, 32'(global_mask));
	endtask

	task automatic none();
		cpu_op(3'h1);
		#1 chk("no push", 32'h0, 32'(push_req));
	endtask

	// ==========================================
	// hang guard
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end

	// ==========================================
	// main sequence
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("reset vector", 32'hfffe, 32'(last_vec));
		chk("vector count", 32'h1, 32'(vec_count));
		rchk("mask", 8'h04, 32'h1);
		rchk("sens", 8'h00, 32'h0);
		rchk("unmapped", 8'h10, 32'h0);
		// peripheral priority and masking
		@(posedge hclk) per_flag <= 13'h1f21;
		repeat (3) @(posedge hclk);
		rchk("pending", 8'h08, 32'h1f21);
		none();
		for (int i = 0; i < 7; i++) begin
			wh = 1'b0;
			for (int j = i; j < 7; j++) wh |= wk[j];
			chk("halt wake", 32'(wh), 32'(wake_halt));
			chk("wait wake", 32'h1, 32'(wake_wait));
			push_delay <= i[0] ? 4'h5 : 4'h0;
			cpu_op(3'h4);
			if (i == 0) rchk("mask clear", 8'h04, 32'h0);
			serve(vtab[i]);
			if (i == 0) none();
			per_flag[src[i]] <= 1'b0;
			repeat (3) @(posedge hclk);
		end
		chk("wait wake", 32'h0, 32'(wake_wait));
		// second timebase alone wakes wait but not halt
		per_flag[5] <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("wait wake", 32'h1, 32'(wake_wait));
		chk("halt wake", 32'h0, 32'(wake_halt));
		per_flag[5] <= 1'b0;
		repeat (3) @(posedge hclk);
		// trap ignores the mask and beats pending sources
		cpu_op(3'h2);
		serve(16'hfffc);
		cpu_op(3'h4);
		@(posedge hclk) per_flag[10] <= 1'b1;
		repeat (3) @(posedge hclk);
		cpu_op(3'h2);
		serve(16'hfffc);
		cpu_op(3'h4);
		serve(16'hffe6);
		per_flag[10] <= 1'b0;
		// enable gate and clearing sequence
		per_en[11] <= 1'b0;
		@(posedge hclk) per_flag[11] <= 1'b1;
		cpu_op(3'h4);
		none();
		@(posedge hclk) per_en[11] <= 1'b1;
		repeat (3) @(posedge hclk);
		serve(16'hffe4);
		per_en[11] <= 1'b0;
		cpu_op(3'h4);
		@(posedge hclk) per_stat_acc[11] <= 1'b1;
		@(posedge hclk) per_stat_acc[11] <= 1'b0;
		per_assoc_acc[11] <= 1'b1;
		@(posedge hclk) per_assoc_acc[11] <= 1'b0;
		@(posedge hclk) per_en[11] <= 1'b1;
		repeat (3) @(posedge hclk);
		none();
		per_flag[11] <= 1'b0;
		// external lines
		ahb(1'b1, 8'h00, 32'hff);
		rchk("sens", 8'h00, 32'h0);
		ahb(1'b1, 8'h04, 32'h1);
		ahb(1'b1, 8'h00, 32'he4);
		rchk("sens", 8'h00, 32'he4);
		@(posedge hclk) ext_pins <= 16'heeee;
		repeat (4) @(posedge hclk);
		rchk("pending", 8'h08, 32'h1a);
		chk("halt wake", 32'h1, 32'(wake_halt));
		@(posedge hclk) ext_pins <= 16'hffff;
		repeat (4) @(posedge hclk);
		rchk("pending", 8'h08, 32'h1e);
		ahb(1'b1, 8'h04, 32'h0);
		serve(16'hfff8);
		rchk("pending", 8'h08, 32'h1c);
		ahb(1'b1, 8'h00, 32'he0);
		rchk("pending", 8'h08, 32'h18);
		ahb(1'b1, 8'h00, 32'he4);
		@(posedge hclk) ext_pin_en <= 16'h1131;
		@(posedge hclk) ext_pins <= 16'hffcf;
		@(posedge hclk) ext_pins <= 16'hffdf;
		repeat (4) @(posedge hclk);
		rchk("pending", 8'h08, 32'h18);
		@(posedge hclk) ext_pins <= 16'hffff;
		repeat (4) @(posedge hclk);
		rchk("pending", 8'h08, 32'h1c);
		for (int k = 1; k < 4; k++) begin
			cpu_op(3'h4);
			serve(16'hfff8 - 16'(2 * k));
		end
		rchk("pending", 8'h08, 32'h0);
		rchk("last vector", 8'h0c, 32'hfff2);
		// reset in mid-run with the mask cleared
		cpu_op(3'h4);
		@(posedge hclk) hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("reset vector", 32'hfffe, 32'(last_vec));
		chk("vector count", 32'h1, 32'(vec_count));
		rchk("mask", 8'h04, 32'h1);
		rchk("sens", 8'h00, 32'h0);
		rchk("pending", 8'h08, 32'h0);
		final_report();
	end
endmodule
